/* File: pmcpo_regs.sv */
// Behaviour
// (R1) Capability version reads as binary 010
// (R2) Device-specific initialisation bit reads zero
// (R3) D1 support bit reads one
// (R4) D2 support bit reads one
// (R5) Wake-event support field reads all zero
// (R6) Data byte read-only, loaded from preload
// (R7) Bits 1-4 enable read/write aliasing
// (R8) Bits 5-6 enable line/multiple aliasing
// (R9) Bits 7-8 disable invalidate aliasing
// (R10) Bit 9 lengthens request for locks
// (R11) Bits 10-11 hold request longer
// (R12) Bits 0 and 15:12 have no function
// (R13) Reserved bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none

module pmcpo_regs (
    input wire logic clk,
    input wire logic nrst,
    input wire logic cfg_rd,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic cfg_rvalid,
    input wire logic pre_wr,
    input wire logic [4:0] pre_idx,
    input wire logic [15:0] pre_data,
    output logic pri_mem_rd_alias,
    output logic pri_mem_wr_alias,
    output logic sec_mem_rd_alias,
    output logic sec_mem_wr_alias,
    output logic pri_rdlm_alias,
    output logic sec_rdlm_alias,
    output logic pri_mwi_alias_dis,
    output logic sec_mwi_alias_dis,
    output logic lock_long_req,
    output logic sec_hold_req,
    output logic pri_hold_req
);

    // Byte-lane merge of a 16-bit field under a write mask
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [1:0] be,
                                            input logic [15:0] wmask);
        logic [15:0] lanes;
        lanes = {{8{be[1]}}, {8{be[0]}}} & wmask;
        merge16 = (old_v & ~lanes) | (new_v & lanes);
    endfunction

    // Preload entry decode, shared by the state logic and the checks
    function automatic logic pre_hit(input logic strobe,
                                     input logic [4:0] idx,
                                     input logic [4:0] entry);
        pre_hit = strobe && (idx == entry);
    endfunction

    // Config offset decode; the bus carries whole dword offsets only
    function automatic logic cfg_hit(input logic strobe,
                                     input logic [7:0] addr,
                                     input logic [7:0] ofs);
        cfg_hit = strobe && (addr == ofs);
    endfunction

    logic [15:0] port_opt_ff;
    logic [15:0] nxt_port_opt;
    logic [7:0] pm_data_ff;
    logic [7:0] nxt_pm_data;
    logic [31:0] nxt_rdata;
    logic nxt_rvalid;
    logic hit_po_wr;
    logic hit_pre_po;
    logic hit_pre_data;
    logic hit_po_rd;
    logic hit_cap_rd;
    logic hit_data_rd;

    // Strobe decodes
    assign hit_po_wr = cfg_hit(cfg_wr, cfg_addr, pmcpo_pkg::PORT_OPT_OFS);
    assign hit_pre_po = pre_hit(pre_wr, pre_idx, pmcpo_pkg::PRE_PORT_OPT_IDX);
    assign hit_pre_data = pre_hit(pre_wr, pre_idx, pmcpo_pkg::PRE_PM_DATA_IDX);
    // Read decodes only feed the checks; the read mux decodes by case
    assign hit_po_rd = cfg_hit(cfg_rd, cfg_addr, pmcpo_pkg::PORT_OPT_OFS);
    assign hit_cap_rd = cfg_hit(cfg_rd, cfg_addr, pmcpo_pkg::PM_CAP_OFS);
    assign hit_data_rd = cfg_hit(cfg_rd, cfg_addr, pmcpo_pkg::PM_DATA_OFS);

    // Register state; a config write beats a preload in the same cycle
    always_comb begin
        nxt_port_opt = port_opt_ff;
        nxt_pm_data = pm_data_ff;
        // (R13) reserved bits masked
        if (hit_pre_po) begin
            nxt_port_opt = pre_data & pmcpo_pkg::PO_WMASK;
        end
        // (R6) preload only source
        if (hit_pre_data) begin
            nxt_pm_data = pre_data[15:8];
        end
        // (R13) masked write lanes
        if (hit_po_wr) begin
            nxt_port_opt = merge16(port_opt_ff, cfg_wdata[15:0], cfg_be[1:0],
                                   pmcpo_pkg::PO_WMASK);
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            port_opt_ff <= pmcpo_pkg::PO_RST;
            pm_data_ff <= pmcpo_pkg::PM_DATA_RST;
        end else begin
            port_opt_ff <= nxt_port_opt;
            pm_data_ff <= nxt_pm_data;
        end
    end

    // Read mux, answered one cycle after the strobe
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        nxt_rvalid = cfg_rd;
        if (cfg_rd) begin
            case (cfg_addr)
                // (R12) reserved bits read zero
                pmcpo_pkg::PORT_OPT_OFS: nxt_rdata = {16'h0000, port_opt_ff};
                // (R1) fixed capability word
                // (R2) no init bit
                // (R3) D1 bit set
                // (R4) D2 bit set
                // (R5) wake field zero
                pmcpo_pkg::PM_CAP_OFS: nxt_rdata = pmcpo_pkg::PM_CAP_VAL;
                // (R6) data byte lane
                pmcpo_pkg::PM_DATA_OFS: nxt_rdata = {pm_data_ff, 24'h00_0000};
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cfg_rdata <= 32'h0000_0000;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rdata <= nxt_rdata;
            cfg_rvalid <= nxt_rvalid;
        end
    end

    // (R7) read/write alias enables
    assign pri_mem_rd_alias = port_opt_ff[pmcpo_pkg::PO_PRI_RD_ALIAS];
    assign pri_mem_wr_alias = port_opt_ff[pmcpo_pkg::PO_PRI_WR_ALIAS];
    assign sec_mem_rd_alias = port_opt_ff[pmcpo_pkg::PO_SEC_RD_ALIAS];
    assign sec_mem_wr_alias = port_opt_ff[pmcpo_pkg::PO_SEC_WR_ALIAS];
    // (R8) line/multiple alias enables
    assign pri_rdlm_alias = port_opt_ff[pmcpo_pkg::PO_PRI_RLM_ALIAS];
    assign sec_rdlm_alias = port_opt_ff[pmcpo_pkg::PO_SEC_RLM_ALIAS];
    // (R9) invalidate alias disables
    assign pri_mwi_alias_dis = port_opt_ff[pmcpo_pkg::PO_PRI_MWI_DIS];
    assign sec_mwi_alias_dis = port_opt_ff[pmcpo_pkg::PO_SEC_MWI_DIS];
    // (R10) long lock request
    assign lock_long_req = port_opt_ff[pmcpo_pkg::PO_LOCK_LONG_REQ];
    // (R11) request hold controls
    assign sec_hold_req = port_opt_ff[pmcpo_pkg::PO_SEC_HOLD_REQ];
    assign pri_hold_req = port_opt_ff[pmcpo_pkg::PO_PRI_HOLD_REQ];

    // Checks; all in one domain
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // (R1) version field
    cap_version_a: assert property ((cfg_rd && cfg_addr == pmcpo_pkg::PM_CAP_OFS) |=> // (R1)
        cfg_rvalid && cfg_rdata[pmcpo_pkg::PM_VER_LSB +: 3] == pmcpo_pkg::PM_VER_VAL)
        else $error("capability version wrong");
    // (R2) no device-specific init
    cap_dsi_a: assert property ((cfg_rd && cfg_addr == pmcpo_pkg::PM_CAP_OFS) |=> // (R2)
        !cfg_rdata[pmcpo_pkg::PM_DSI_BIT])
        else $error("dsi bit set");
    // (R3) D1 support
    cap_d1_a: assert property ((cfg_rd && cfg_addr == pmcpo_pkg::PM_CAP_OFS) |=> // (R3)
        cfg_rdata[pmcpo_pkg::PM_D1_BIT])
        else $error("D1 support missing");
    // (R4) D2 support
    cap_d2_a: assert property ((cfg_rd && cfg_addr == pmcpo_pkg::PM_CAP_OFS) |=> // (R4)
        cfg_rdata[pmcpo_pkg::PM_D2_BIT])
        else $error("D2 support missing");
    // (R5) no wake events
    cap_wake_a: assert property ((cfg_rd && cfg_addr == pmcpo_pkg::PM_CAP_OFS) |=> // (R5)
        cfg_rdata[31:pmcpo_pkg::PM_WAKE_LSB] == 5'h00)
        else $error("wake support nonzero");
    // (R6) data byte unchanged by writes
    pm_data_ro_a: assert property ((cfg_wr && !(pre_wr && // (R6)
        pre_idx == pmcpo_pkg::PRE_PM_DATA_IDX)) |=> $stable(pm_data_ff))
        else $error("data byte changed by write");
    // (R6) preload reaches the read path
    pm_data_load_a: assert property (hit_pre_data ##1 !pre_wr ##1 (hit_data_rd && !pre_wr) // (R6)
        |=> cfg_rdata[31:24] == $past(pre_data[15:8], 3))
        else $error("data byte not loaded");
    // (R7) write takes effect next cycle
    alias_wr_a: assert property ((hit_po_wr && cfg_be[0] && !pre_wr) |=> // (R7)
        pri_mem_rd_alias == $past(cfg_wdata[1]) && sec_mem_wr_alias == $past(cfg_wdata[4]))
        else $error("alias enable not written");
    // (R11) upper lane write
    hold_wr_a: assert property ((hit_po_wr && cfg_be[1]) |=> // (R11)
        pri_hold_req == $past(cfg_wdata[11]) && lock_long_req == $past(cfg_wdata[9]))
        else $error("hold control not written");
    // (R13) reserved bits stay zero
    po_resv_a: assert property (1'b1 |-> (port_opt_ff & ~pmcpo_pkg::PO_WMASK) == 16'h0000) // (R13)
        else $error("reserved port option bit set");
    // (R12) reserved bits read zero
    po_read_a: assert property ((cfg_rd && cfg_addr == pmcpo_pkg::PORT_OPT_OFS) |=> // (R12)
        cfg_rdata[0] == 1'b0 && cfg_rdata[31:12] == 20'h0_0000)
        else $error("reserved bits read nonzero");
    // Unmapped reads answer zero
    unmapped_rd_a: assert property ((cfg_rd && cfg_addr != pmcpo_pkg::PORT_OPT_OFS &&
        cfg_addr != pmcpo_pkg::PM_CAP_OFS && cfg_addr != pmcpo_pkg::PM_DATA_OFS)
        |=> cfg_rvalid && cfg_rdata == 32'h0000_0000)
        else $error("unmapped read nonzero");

    // (R13) reserved and unused capability bits read zero
    cap_resv_a: assert property (hit_cap_rd |=> // (R13)
        cfg_rdata[15:0] == 16'h0000 && cfg_rdata[20:19] == 2'h0 && cfg_rdata[24:22] == 3'h0)
        else $error("capability reserved bits set");
    // (R6) data byte reaches the top lane, low lanes zero
    pm_data_rd_a: assert property (hit_data_rd |=> // (R6)
        cfg_rvalid && cfg_rdata == {$past(pm_data_ff), 24'h00_0000})
        else $error("data byte read wrong");
    // (R6) only its own preload entry moves the data byte
    pm_data_hold_a: assert property (!hit_pre_data |=> $stable(pm_data_ff)) // (R6)
        else $error("data byte moved without preload");
    // (R6) preload entry loads the high byte
    pm_pre_load_a: assert property (hit_pre_data |=> // (R6)
        pm_data_ff == $past(pre_data[15:8]))
        else $error("data byte preload lost");

    // (R7) remaining read/write alias bits, low lane
    alias_rest_a: assert property ((hit_po_wr && cfg_be[0]) |=> // (R7)
        pri_mem_wr_alias == $past(cfg_wdata[2]) && sec_mem_rd_alias == $past(cfg_wdata[3]))
        else $error("other alias enables not written");
    // (R8) line/multiple alias bits, low lane
    rdlm_wr_a: assert property ((hit_po_wr && cfg_be[0]) |=> // (R8)
        pri_rdlm_alias == $past(cfg_wdata[5]) && sec_rdlm_alias == $past(cfg_wdata[6]))
        else $error("line alias enable not written");
    // (R9) primary invalidate disable sits in the low lane
    mwi_pri_a: assert property ((hit_po_wr && cfg_be[0]) |=> // (R9)
        pri_mwi_alias_dis == $past(cfg_wdata[7]))
        else $error("primary invalidate disable not written");
    // (R9) secondary invalidate disable sits in the high lane
    mwi_sec_a: assert property ((hit_po_wr && cfg_be[1]) |=> // (R9)
        sec_mwi_alias_dis == $past(cfg_wdata[8]))
        else $error("secondary invalidate disable not written");
    // (R10) lock request control, high lane
    lock_wr_a: assert property ((hit_po_wr && cfg_be[1]) |=> // (R10)
        lock_long_req == $past(cfg_wdata[9]))
        else $error("lock request control not written");
    // (R11) secondary hold control
    hold_sec_a: assert property ((hit_po_wr && cfg_be[1]) |=> // (R11)
        sec_hold_req == $past(cfg_wdata[10]))
        else $error("secondary hold control not written");

    // (R13) disabled lanes keep their contents, even against a preload
    lane_lo_keep_a: assert property ((hit_po_wr && !cfg_be[0]) |=> // (R13)
        port_opt_ff[7:0] == $past(port_opt_ff[7:0]))
        else $error("low lane changed without enable");
    lane_hi_keep_a: assert property ((hit_po_wr && !cfg_be[1]) |=> // (R13)
        port_opt_ff[15:8] == $past(port_opt_ff[15:8]))
        else $error("high lane changed without enable");
    // (R13) preload masks the reserved bits
    pre_po_load_a: assert property ((hit_pre_po && !hit_po_wr) |=> // (R13)
        port_opt_ff == ($past(pre_data) & pmcpo_pkg::PO_WMASK))
        else $error("option preload wrong");
    // Config write wins a clash with the option preload
    wr_wins_a: assert property ((hit_po_wr && hit_pre_po && cfg_be[1:0] == 2'h3) |=>
        port_opt_ff == ($past(cfg_wdata[15:0]) & pmcpo_pkg::PO_WMASK))
        else $error("preload beat config write");
    // Options move only on a write or their own preload
    po_idle_a: assert property ((!hit_po_wr && !hit_pre_po) |=> $stable(port_opt_ff))
        else $error("port options moved while idle");

    // (R12) read returns the contents before a same-cycle write
    po_rd_old_a: assert property (hit_po_rd |=> // (R12)
        cfg_rdata[15:0] == $past(port_opt_ff))
        else $error("port option read wrong");
    // One answer per read, then the data lines fall back to zero
    rd_answer_a: assert property (cfg_rd |=> cfg_rvalid)
        else $error("read not answered");
    rd_idle_a: assert property (!cfg_rd |=> !cfg_rvalid && cfg_rdata == 32'h0000_0000)
        else $error("answer without a read");
    // Reset clears state and the answer path; checked through reset itself
    reset_state_a: assert property (disable iff (1'b0) !nrst |=>
        port_opt_ff == pmcpo_pkg::PO_RST && pm_data_ff == pmcpo_pkg::PM_DATA_RST && !cfg_rvalid)
        else $error("reset state wrong");

    cap_read_c: cover property (cfg_rd && cfg_addr == pmcpo_pkg::PM_CAP_OFS);
    po_write_read_c: cover property (hit_po_wr ##1 (cfg_rd && cfg_addr == pmcpo_pkg::PORT_OPT_OFS));
    preload_c: cover property (pre_wr && pre_idx == pmcpo_pkg::PRE_PORT_OPT_IDX);
    wr_pre_clash_c: cover property (hit_po_wr && pre_wr && pre_idx == pmcpo_pkg::PRE_PORT_OPT_IDX);
    rd_wr_same_c: cover property (hit_po_rd && hit_po_wr);

endmodule // pmcpo_regs

`default_nettype wire

/* File: pmcpo_pkg.sv */
`default_nettype none

package pmcpo_pkg;
    // Configuration dword byte offsets
    localparam logic [7:0] PORT_OPT_OFS = 8'h74;
    localparam logic [7:0] PM_CAP_OFS = 8'h80;
    localparam logic [7:0] PM_DATA_OFS = 8'h84;

    // Preload table entries feeding this slice
    localparam logic [4:0] PRE_PM_DATA_IDX = 5'h0D;
    localparam logic [4:0] PRE_PORT_OPT_IDX = 5'h0E;

    // Capability dword fields
    localparam int PM_VER_LSB = 16;
    localparam logic [2:0] PM_VER_VAL = 3'h2;
    localparam int PM_DSI_BIT = 21;
    localparam int PM_D1_BIT = 25;
    localparam int PM_D2_BIT = 26;
    localparam int PM_WAKE_LSB = 27;
    localparam logic [31:0] PM_CAP_VAL = 32'h0602_0000;

    // Data byte sits in the top byte lane
    localparam int PM_DATA_LSB = 24;
    localparam logic [7:0] PM_DATA_RST = 8'h00;

    // Port option fields
    localparam int PO_PRI_RD_ALIAS = 1;
    localparam int PO_PRI_WR_ALIAS = 2;
    localparam int PO_SEC_RD_ALIAS = 3;
    localparam int PO_SEC_WR_ALIAS = 4;
    localparam int PO_PRI_RLM_ALIAS = 5;
    localparam int PO_SEC_RLM_ALIAS = 6;
    localparam int PO_PRI_MWI_DIS = 7;
    localparam int PO_SEC_MWI_DIS = 8;
    localparam int PO_LOCK_LONG_REQ = 9;
    localparam int PO_SEC_HOLD_REQ = 10;
    localparam int PO_PRI_HOLD_REQ = 11;
    localparam logic [15:0] PO_WMASK = 16'h0FFE;
    localparam logic [15:0] PO_RST = 16'h0000;
endpackage

`default_nettype wire

/* File: pmcpo_host.sv */
`timescale 1ns/1ps
`default_nettype none

// Primary host issuing configuration cycles, one request at a time
module pmcpo_host (
    input wire logic clk,
    output logic cfg_rd,
    output logic cfg_wr,
    output logic [7:0] cfg_addr,
    output logic [3:0] cfg_be,
    output logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_rvalid
);
    // Idle bus before the first request
    initial begin
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        cfg_addr = 8'h00;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0000_0000;
    end

    // One-cycle write strobe; data turned over after so stale data never matches
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge clk);
        #1;
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = d;
        @(posedge clk);
        #1;
        cfg_wr = 1'b0;
        cfg_be = 4'h0;
        cfg_wdata = ~d;
    endtask

    // Read and write in one cycle; the read answers with the old contents
    task automatic rw(input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd,
                      output logic [31:0] d, output logic ok);
        @(posedge clk);
        #1;
        cfg_rd = 1'b1;
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = wd;
        @(posedge clk);
        #1;
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        cfg_be = 4'h0;
        cfg_wdata = ~wd;
        ok = 1'b0;
        d = 32'h0000_0000;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (cfg_rvalid === 1'b1) begin
                ok = 1'b1;
                d = cfg_rdata;
            end else begin
                @(posedge clk);
                #1;
            end
        end
    endtask

    // Read strobe, then a bounded wait for the answer
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic ok);
        @(posedge clk);
        #1;
        cfg_rd = 1'b1;
        cfg_addr = a;
        @(posedge clk);
        #1;
        cfg_rd = 1'b0;
        cfg_addr = ~a;
        ok = 1'b0;
        d = 32'h0000_0000;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (cfg_rvalid === 1'b1) begin
                ok = 1'b1;
                d = cfg_rdata;
            end else begin
                @(posedge clk);
                #1;
            end
        end
    endtask
endmodule // pmcpo_host

`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic pre_wr = 1'b0;
    logic [4:0] pre_idx = 5'h00;
    logic [15:0] pre_data = 16'h0000;
    logic cfg_rd, cfg_wr, cfg_rvalid;
    logic [7:0] cfg_addr;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic [11:1] opt;
    int error_cnt = 0;
    int checks = 0;

    // 25 MHz clock
    always #20 clk = ~clk;

    pmcpo_host pmcpo_host_i (.clk(clk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));

    pmcpo_regs pmcpo_regs_i (.clk(clk), .nrst(nrst), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .pre_wr(pre_wr), .pre_idx(pre_idx), .pre_data(pre_data),
        .pri_mem_rd_alias(opt[1]), .pri_mem_wr_alias(opt[2]), .sec_mem_rd_alias(opt[3]),
        .sec_mem_wr_alias(opt[4]), .pri_rdlm_alias(opt[5]), .sec_rdlm_alias(opt[6]),
        .pri_mwi_alias_dis(opt[7]), .sec_mwi_alias_dis(opt[8]), .lock_long_req(opt[9]),
        .sec_hold_req(opt[10]), .pri_hold_req(opt[11]));

    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // A missing answer ends the run at once
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic ok;
        pmcpo_host_i.rd(a, d, ok);
        if (!ok) begin
            error_cnt++;
            $display("BAD %0t no read answer", $time);
            tally_and_finish();
        end else begin
            chk(d, exp);
        end
    endtask

    task automatic pre(input logic [4:0] idx, input logic [15:0] d);
        @(posedge clk);
        #1;
        pre_wr = 1'b1;
        pre_idx = idx;
        pre_data = d;
        @(posedge clk);
        #1;
        pre_wr = 1'b0;
    endtask

    // Fixed capability dword, writes to it ignored
    task automatic t_cap;
        rd_chk(8'h80, 32'h0602_0000);
        pmcpo_host_i.wr(8'h80, 4'hF, 32'hFFFF_FFFF);
        rd_chk(8'h80, 32'h0602_0000);
    endtask

    // Walk a one through every bit, then each byte lane alone
    task automatic t_opts;
        logic [31:0] e;
        for (int i = 0; i < 16; i++) begin
            e = (32'h0000_0001 << i) & 32'h0000_0FFE;
            pmcpo_host_i.wr(8'h74, 4'h3, 32'hFFFF_0000 | (32'h0000_0001 << i));
            chk({20'h00000, opt, 1'b0}, e);
            rd_chk(8'h74, e);
        end
        pmcpo_host_i.wr(8'h74, 4'h1, 32'hFFFF_FFFF);
        chk({20'h00000, opt, 1'b0}, 32'h0000_00FE);
        pmcpo_host_i.wr(8'h74, 4'h2, 32'hFFFF_FFFF);
        rd_chk(8'h74, 32'h0000_0FFE);
    endtask

    // Preload feeds the data byte and the options; config writes cannot touch the byte
    task automatic t_pre;
        pre(5'h0D, 16'hAB00);
        rd_chk(8'h84, 32'hAB00_0000);
        pmcpo_host_i.wr(8'h84, 4'hF, 32'h0000_0000);
        rd_chk(8'h84, 32'hAB00_0000);
        pre(5'h0E, 16'hF5A5);
        rd_chk(8'h74, 32'h0000_05A4);
        rd_chk(8'h90, 32'h0000_0000);
    endtask

    // Write against preload, foreign entry, answer release, read with write
    task automatic t_clash;
        logic [31:0] d;
        logic ok;
        fork
            pmcpo_host_i.wr(8'h74, 4'h3, 32'h0000_00F0);
            pre(5'h0E, 16'hFFFF);
        join
        rd_chk(8'h74, 32'h0000_00F0);
        @(posedge clk);
        #1;
        chk(cfg_rdata, 32'h0000_0000);
        chk({31'h0, cfg_rvalid}, 32'h0000_0000);
        pre(5'h0C, 16'hFFFF);
        rd_chk(8'h74, 32'h0000_00F0);
        rd_chk(8'h84, 32'hAB00_0000);
        pmcpo_host_i.rw(8'h74, 4'h3, 32'h0000_0F0E, d, ok);
        chk({31'h0, ok}, 32'h0000_0001);
        chk(d, 32'h0000_00F0);
        chk({20'h00000, opt, 1'b0}, 32'h0000_0F0E);
        rd_chk(8'h74, 32'h0000_0F0E);
    endtask

    // Mid-run reset clears what preload and writes left behind
    task automatic t_reset;
        pre(5'h0D, 16'h5A00);
        rd_chk(8'h84, 32'h5A00_0000);
        @(posedge clk);
        #1;
        nrst = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        nrst = 1'b1;
        chk({20'h00000, opt, 1'b0}, 32'h0000_0000);
        rd_chk(8'h74, 32'h0000_0000);
        rd_chk(8'h84, 32'h0000_0000);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        #1;
        nrst = 1'b1;
        chk({20'h00000, opt, 1'b0}, 32'h0000_0000);
        rd_chk(8'h74, 32'h0000_0000);
        rd_chk(8'h84, 32'h0000_0000);
        t_cap();
        t_opts();
        t_pre();
        t_clash();
        t_reset();
        tally_and_finish();
    end
endmodule // tb_top

`default_nettype wire
